/* File: hdl/bic_pkg.sv */
// impedance channel configuration: register map, field layout, reset values
// assumes a 32-bit axi4-lite register bus with one aligned word per register
package bic_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_GEN_CFG = 8'h10;  // general_configuration
  localparam logic [7:0] ADDR_IMP_CFG = 8'h18;  // impedance_channel_configuration
  localparam logic [7:0] ADDR_RESYNC  = 8'h20;  // resynchronize_command, write only
  localparam logic [7:0] ADDR_STATUS  = 8'h24;  // record state, read only
  localparam int         ADDR_W       = 8;

  // impedance_channel_configuration field positions
  localparam int CFG_W       = 24;
  localparam int RATE_BIT    = 23;
  localparam int AHPF_LSB    = 20;
  localparam int EXT_BIAS    = 19;
  localparam int LOW_NOISE   = 18;
  localparam int GAIN_LSB    = 16;
  localparam int DHPF_LSB    = 14;
  localparam int DLPF_LSB    = 12;
  localparam int CG_W        = 12;

  // reset values
  localparam logic [23:0] IMP_CFG_RST = 24'h201000;
  localparam logic [1:0]  GEN_CFG_RST = 2'h0;

  // low-pass codes
  localparam logic [1:0] LPF_BYPASS = 2'h0;
  localparam logic [1:0] LPF_4HZ    = 2'h1;
  localparam logic [1:0] LPF_16HZ   = 2'h3;

  // master clock selections
  localparam logic [1:0] MCLK_SEL_0 = 2'h0;
  localparam logic [1:0] MCLK_SEL_1 = 2'h1;
  localparam logic [1:0] MCLK_SEL_2 = 2'h2;

  // sample rates in hundredths of a sample per second
  localparam logic [12:0] RATE_64    = 13'h1900;  // 6400
  localparam logic [12:0] RATE_32    = 13'h0c80;  // 3200
  localparam logic [12:0] RATE_62_5  = 13'h186a;  // 6250
  localparam logic [12:0] RATE_31_25 = 13'h0c35;  // 3125
  localparam logic [12:0] RATE_50    = 13'h1388;  // 5000
  localparam logic [12:0] RATE_25    = 13'h09c4;  // 2500
  localparam logic [12:0] RATE_49_95 = 13'h1383;  // 4995
  localparam logic [12:0] RATE_24_98 = 13'h09c2;  // 2498

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/bic_decode.sv */
// impedance channel configuration: decodes stored fields into settings
// assumes inputs come from registers on the same clock; purely combinational
`timescale 1ns/1ps
module bic_decode (
  input  wire logic [23:0] cfg,
  input  wire logic [1:0]  mclk_sel,
  output logic      [1:0]  lpf_eff,
  output logic      [12:0] rate_csps,
  output logic      [12:0] ahpf_hz,
  output logic             ahpf_byp,
  output logic      [6:0]  gain_vv,
  output logic      [5:0]  dhpf_chz
);
  logic       rate_half;
  logic [1:0] lpf_wr;

  assign rate_half = cfg[bic_pkg::RATE_BIT];
  assign lpf_wr    = cfg[bic_pkg::DLPF_LSB +: 2];

  // sample rate from clock selection and rate bit
  // rate table
  always_comb begin
    case (mclk_sel)
      bic_pkg::MCLK_SEL_0: rate_csps = rate_half ? bic_pkg::RATE_32 : bic_pkg::RATE_64;
      bic_pkg::MCLK_SEL_1: rate_csps = rate_half ? bic_pkg::RATE_31_25 : bic_pkg::RATE_62_5;
      bic_pkg::MCLK_SEL_2: rate_csps = rate_half ? bic_pkg::RATE_25 : bic_pkg::RATE_50;
      default:             rate_csps = rate_half ? bic_pkg::RATE_24_98 : bic_pkg::RATE_49_95;
    endcase
  end

  // 16 Hz only at the faster rate, otherwise fall back to 4 Hz
  // low-pass fallback
  always_comb begin
    if (lpf_wr == bic_pkg::LPF_16HZ && rate_half) begin
      lpf_eff = bic_pkg::LPF_4HZ;
    end else begin
      lpf_eff = lpf_wr;
    end
  end

  // analog high-pass cutoff; 11x bypasses
  always_comb begin
    ahpf_byp = 1'b0;
    case (cfg[bic_pkg::AHPF_LSB +: 3])
      3'h0:    ahpf_hz = 13'h003c;
      3'h1:    ahpf_hz = 13'h0096;
      3'h2:    ahpf_hz = 13'h01f4;
      3'h3:    ahpf_hz = 13'h03e8;
      3'h4:    ahpf_hz = 13'h07d0;
      3'h5:    ahpf_hz = 13'h0fa0;
      default: begin
        ahpf_hz  = 13'h0000;
        ahpf_byp = 1'b1;
      end
    endcase
  end

  // gain doubles per code step; digital high-pass in hundredths of hz
  always_comb begin
    gain_vv = 7'(7'h0a << cfg[bic_pkg::GAIN_LSB +: 2]);
    case (cfg[bic_pkg::DHPF_LSB +: 2])
      2'h0:    dhpf_chz = 6'h00;
      2'h1:    dhpf_chz = 6'h05;
      default: dhpf_chz = 6'h32;
    endcase
  end
endmodule

/* File: hdl/bic_top.sv */
// impedance channel configuration register block with axi4-lite slave
// assumes one 40 MHz clock mclk, synchronous active-low reset rst_b
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module bic_top (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [12:0] sample_rate_csps,
  output logic      [12:0] analog_highpass_hz,
  output logic             analog_highpass_bypass,
  output logic             external_bias_resistor_enable,
  output logic             impedance_amp_low_noise,
  output logic      [6:0]  gain_vv,
  output logic      [5:0]  digital_highpass_chz,
  output logic      [1:0]  lowpass_select_effective,
  output logic      [11:0] current_gen_cfg,
  output logic             resync_pulse,
  output logic             record_disturbed
);
  logic [23:0] cfg_reg;
  logic [1:0]  mclk_sel_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_wr;
  logic        wr_cfg;
  logic        wr_gen;
  logic        wr_sync;
  logic        rd_take;
  logic [23:0] cfg_next;
  logic [1:0]  lpf_eff;
  logic [12:0] rate_d;
  logic [12:0] ahpf_d;
  logic        ahpf_byp_d;
  logic [6:0]  gain_d;
  logic [5:0]  dhpf_d;
  logic [31:0] rdata_next;
  logic [1:0]  rresp_next;

  // field decoder
  bic_decode u_dec (
    .cfg       (cfg_reg),
    .mclk_sel  (mclk_sel_reg),
    .lpf_eff   (lpf_eff),
    .rate_csps (rate_d),
    .ahpf_hz   (ahpf_d),
    .ahpf_byp  (ahpf_byp_d),
    .gain_vv   (gain_d),
    .dhpf_chz  (dhpf_d)
  );

  // write happens once both address and data are held and no response pends
  assign do_wr   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_cfg  = do_wr && awaddr_reg == bic_pkg::ADDR_IMP_CFG;
  assign wr_gen  = do_wr && awaddr_reg == bic_pkg::ADDR_GEN_CFG;
  assign wr_sync = do_wr && awaddr_reg == bic_pkg::ADDR_RESYNC && wstrb_reg[0] && wdata_reg[0];
  assign rd_take = s_axi_arvalid & s_axi_arready;

  // write address channel, taken in either order with data
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      awaddr_reg    <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_reg    <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_wready <= 1'b1;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response; unmapped or read-only addresses answer slverr
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bic_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_reg == bic_pkg::ADDR_IMP_CFG || awaddr_reg == bic_pkg::ADDR_GEN_CFG ||
          awaddr_reg == bic_pkg::ADDR_RESYNC) begin
        s_axi_bresp <= bic_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= bic_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte-lane merge of the configuration word
  always_comb begin
    cfg_next = cfg_reg;
    for (int i = 0; i < 3; i++) begin
      if (wstrb_reg[i]) begin
        cfg_next[i*8 +: 8] = wdata_reg[i*8 +: 8];
      end
    end
  end

  // configuration register keeps every field as written
  // stored unchanged
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_reg <= bic_pkg::IMP_CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg <= cfg_next;
    end
  end

  // master clock selection in the general configuration word
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mclk_sel_reg <= bic_pkg::GEN_CFG_RST;
    end else if (wr_gen && wstrb_reg[0]) begin
      mclk_sel_reg <= wdata_reg[1:0];
    end
  end

  // record disturbed by a config write until resync; set wins over clear
  // disturb and resync
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      record_disturbed <= 1'b0;
      resync_pulse     <= 1'b0;
    end else begin
      resync_pulse <= wr_sync;
      if (wr_cfg || wr_gen) begin
        record_disturbed <= 1'b1;
      end else if (wr_sync) begin
        record_disturbed <= 1'b0;
      end
    end
  end

  // read data select; low-pass field returns the effective code
  always_comb begin
    rdata_next = 32'h00000000;
    rresp_next = bic_pkg::RESP_OKAY;
    case (s_axi_araddr)
      bic_pkg::ADDR_IMP_CFG: rdata_next[23:0] = {cfg_reg[23:14], lpf_eff, cfg_reg[11:0]};
      bic_pkg::ADDR_GEN_CFG: rdata_next[1:0] = mclk_sel_reg;
      bic_pkg::ADDR_STATUS:  rdata_next[0] = record_disturbed;
      bic_pkg::ADDR_RESYNC:  rdata_next = 32'h00000000;  // write only, reads zero
      default:               rresp_next = bic_pkg::RESP_SLVERR;
    endcase
  end

  // read channel: one read at a time, arready drops until rready
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= bic_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rresp_next;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // registered channel settings toward the analog and filter paths
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sample_rate_csps              <= bic_pkg::RATE_64;
      analog_highpass_hz            <= 13'h01f4;
      analog_highpass_bypass        <= 1'b0;
      external_bias_resistor_enable <= 1'b0;
      impedance_amp_low_noise       <= 1'b0;
      gain_vv                       <= 7'h0a;
      digital_highpass_chz          <= 6'h00;
      lowpass_select_effective      <= bic_pkg::LPF_4HZ;
      current_gen_cfg               <= 12'h000;
    end else begin
      sample_rate_csps              <= rate_d;
      analog_highpass_hz            <= ahpf_d;
      analog_highpass_bypass        <= ahpf_byp_d;
      external_bias_resistor_enable <= cfg_reg[bic_pkg::EXT_BIAS];
      impedance_amp_low_noise       <= cfg_reg[bic_pkg::LOW_NOISE];
      gain_vv                       <= gain_d;
      digital_highpass_chz          <= dhpf_d;
      lowpass_select_effective      <= lpf_eff;
      current_gen_cfg               <= cfg_reg[bic_pkg::CG_W-1:0];
    end
  end

  // checks on the decoded settings and bus behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence cfg_wr_s;
    wr_cfg;
  endsequence

  sequence rd_cfg_s;
    rd_take && s_axi_araddr == bic_pkg::ADDR_IMP_CFG;
  endsequence

  sequence resync_only_s;
    wr_sync && !wr_cfg && !wr_gen;
  endsequence

  rate_fast_a: assert property (
    !cfg_reg[bic_pkg::RATE_BIT] && mclk_sel_reg == 2'h0 |=> sample_rate_csps == 13'h1900)
    else $error("rate not 64 sps");
  rate_slow_a: assert property (
    cfg_reg[bic_pkg::RATE_BIT] && mclk_sel_reg == 2'h3 |=> sample_rate_csps == 13'h09c2)
    else $error("rate not 24.98 sps");
  ahpf_bypass_a: assert property (
    cfg_reg[22:21] == 2'h3 |=> analog_highpass_bypass && analog_highpass_hz == 13'h0)
    else $error("analog high-pass not bypassed");
  bias_source_a: assert property (
    ##1 external_bias_resistor_enable == $past(cfg_reg[19]))
    else $error("bias source mismatch");
  amp_mode_a: assert property (
    ##1 impedance_amp_low_noise == $past(cfg_reg[18]))
    else $error("amplifier mode mismatch");
  gain_top_a: assert property (
    cfg_reg[17:16] == 2'h3 |=> gain_vv == 7'h50)
    else $error("gain not 80");
  dhpf_half_a: assert property (
    cfg_reg[15] |=> digital_highpass_chz == 6'h32)
    else $error("digital high-pass not 0.50 Hz");
  lpf_pass_a: assert property (
    cfg_reg[13:12] != 2'h3 |=> lowpass_select_effective == $past(cfg_reg[13:12]))
    else $error("supported low-pass altered");
  lpf_remap_a: assert property (
    cfg_reg[13:12] == 2'h3 && cfg_reg[23] |=> lowpass_select_effective == 2'h1)
    else $error("unsupported low-pass not remapped");
  lpf_fast_a: assert property (
    cfg_reg[13:12] == 2'h3 && !cfg_reg[23] |=> lowpass_select_effective == 2'h3)
    else $error("16 Hz refused at fast rate");
  cfg_readback_a: assert property (
    rd_cfg_s |=> s_axi_rvalid && s_axi_rdata[13:12] == $past(lpf_eff) &&
                 s_axi_rdata[23:14] == $past(cfg_reg[23:14]))
    else $error("readback not effective value");
  disturb_set_a: assert property (
    cfg_wr_s |=> record_disturbed)
    else $error("config write did not mark record");
  resync_clear_a: assert property (
    resync_only_s |=> !record_disturbed && resync_pulse ##1 !resync_pulse)
    else $error("resync did not restore");
  cg_keep_a: assert property (
    cfg_wr_s and wstrb_reg[1:0] == 2'h3 |=> cfg_reg[11:0] == $past(wdata_reg[11:0]))
    else $error("current generator bits changed");
  rate_mid_a: assert property (
    cfg_reg[bic_pkg::RATE_BIT] && mclk_sel_reg == 2'h1 |=> sample_rate_csps == 13'h0c35)
    else $error("rate not 31.25 sps");
  rate_sel2_a: assert property (
    !cfg_reg[bic_pkg::RATE_BIT] && mclk_sel_reg == 2'h2 |=> sample_rate_csps == 13'h1388)
    else $error("rate not 50 sps");
  ahpf_low_a: assert property (
    cfg_reg[22:20] == 3'h0 |=> !analog_highpass_bypass && analog_highpass_hz == 13'h003c)
    else $error("analog high-pass not 60 Hz");
  ahpf_top_a: assert property (
    cfg_reg[22:20] == 3'h5 |=> !analog_highpass_bypass && analog_highpass_hz == 13'h0fa0)
    else $error("analog high-pass not 4000 Hz");
  gain_base_a: assert property (
    cfg_reg[17:16] == 2'h0 |=> gain_vv == 7'h0a)
    else $error("gain not 10");
  dhpf_dc_a: assert property (
    cfg_reg[15:14] == 2'h0 |=> digital_highpass_chz == 6'h00)
    else $error("digital high-pass not bypassed");
  dhpf_low_a: assert property (
    cfg_reg[15:14] == 2'h1 |=> digital_highpass_chz == 6'h05)
    else $error("digital high-pass not 0.05 Hz");
  lpf_stored_a: assert property (
    wr_cfg && wstrb_reg[1] |=> cfg_reg[13:12] == $past(wdata_reg[13:12]))
    else $error("low-pass code not stored as written");
  cfg_hold_a: assert property (
    !wr_cfg |=> cfg_reg == $past(cfg_reg))
    else $error("configuration changed without a write");
  cg_out_a: assert property (
    ##1 current_gen_cfg == $past(cfg_reg[11:0]))
    else $error("current generator output mismatch");
  rd_answer_a: assert property (
    rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  wr_answer_a: assert property (
    do_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered");
  resync_pulse_a: assert property (
    resync_pulse |-> $past(wr_sync))
    else $error("resync pulse without command");
endmodule

/* File: dv/tb.sv */
// self-checking bench for the impedance channel configuration register block
// assumes bic_pkg and bic_top are compiled first; the bench is the axi4-lite master
`timescale 1ns/1ps
module tb;
  logic        mclk, rst_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, lpf_eff, eff;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ahpf_byp, ext_bias, low_noise;
  logic        resync, disturbed;
  logic [12:0] rate, ahpf_hz;
  logic [6:0]  gain;
  logic [5:0]  dhpf;
  logic [11:0] cg;
  int          n_fail, n_compared, n_pulse, p0;
  logic [12:0] rate_tab [8];
  logic [12:0] ahpf_tab [8];

  bic_top DUT (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_rate_csps(rate),
    .analog_highpass_hz(ahpf_hz), .analog_highpass_bypass(ahpf_byp),
    .external_bias_resistor_enable(ext_bias), .impedance_amp_low_noise(low_noise),
    .gain_vv(gain), .digital_highpass_chz(dhpf), .lowpass_select_effective(lpf_eff),
    .current_gen_cfg(cg), .resync_pulse(resync), .record_disturbed(disturbed));

  // clock generation, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // counts resync pulses, sampled away from the launching edge
  always @(negedge mclk) begin
    if (resync === 1'b1) n_pulse++;
  end

  task automatic test_done();
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
    logic aw_t, w_t, b_t;
    int   n;
    n = 0;
    b_t = 1'b0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= wd;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_t) begin
      @(negedge mclk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t  = s_axi_wvalid & s_axi_wready;
      b_t  = s_axi_bvalid & s_axi_bready;
      resp = s_axi_bresp;
      @(posedge mclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
      n++;
      if (n > 100) begin
        n_fail++;
        test_done();
      end
    end
  endtask

  // one read: data and response taken at the edge where rvalid is seen
  task automatic axi_rd(input logic [7:0] a);
    logic ar_t, r_t;
    int   n;
    n = 0;
    r_t = 1'b0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_t) begin
      @(negedge mclk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t  = s_axi_rvalid & s_axi_rready;
      rd   = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge mclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
      n++;
      if (n > 100) begin
        n_fail++;
        test_done();
      end
    end
  endtask

  // lets the decoded outputs land, then parks between edges
  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    test_done();
  end

  initial begin
    rate_tab = '{13'h1900, 13'h0c80, 13'h186a, 13'h0c35, 13'h1388, 13'h09c4, 13'h1383, 13'h09c2};
    ahpf_tab = '{13'h003c, 13'h0096, 13'h01f4, 13'h03e8, 13'h07d0, 13'h0fa0, 13'h0, 13'h0};
    n_fail = 0;
    n_compared = 0;
    n_pulse = 0;
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    // reset values of register and decoded settings
    axi_rd(bic_pkg::ADDR_IMP_CFG);
    chk(rd, 32'h00201000);
    chk(rate, 13'h1900);
    chk(ahpf_hz, 13'h01f4);
    chk({ext_bias, low_noise}, 2'h0);
    chk(gain, 7'h0a);
    chk(dhpf, 6'h00);
    chk(lpf_eff, 2'h1);
    $display("test reset done");
    // rate for each master clock selection and rate bit
    for (int s = 0; s < 4; s++) begin
      for (int b = 0; b < 2; b++) begin
        axi_wr(bic_pkg::ADDR_GEN_CFG, 32'(s), 4'h1);
        axi_wr(bic_pkg::ADDR_IMP_CFG, 32'h00201000 | (32'(b) << 23), 4'h7);
        settle();
        chk(rate, 32'(rate_tab[s * 2 + b]));
      end
    end
    axi_rd(bic_pkg::ADDR_GEN_CFG);
    chk(rd, 32'h00000003);
    $display("test rate done");
    // every analog and digital high-pass, bias, amplifier and gain code, with the current generator bits carried through
    for (int i = 0; i < 8; i++) begin
      d = {8'h00, 1'b0, 3'(i), i[0], i[1], i[1:0], i[1:0], 2'h1, 4'(i), 8'ha5};
      axi_wr(bic_pkg::ADDR_IMP_CFG, d, 4'h7);
      chk(resp, 2'h0);
      settle();
      chk(ahpf_hz, 32'(ahpf_tab[i]));
      chk(ahpf_byp, 32'(i >= 6));
      chk(ext_bias, 32'(i[0]));
      chk(low_noise, 32'(i[1]));
      chk(gain, 32'(7'h0a << i[1:0]));
      chk(dhpf, (i[1:0] == 0) ? 32'h0 : (i[1:0] == 1) ? 32'h5 : 32'h32);
      chk(cg, {20'h0, 4'(i), 8'ha5});
      axi_rd(bic_pkg::ADDR_IMP_CFG);
      chk(rd, d);
    end
    $display("test fields done");
    // low-pass codes at both rates, effective code read back
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 4; c++) begin
        d = 32'h00201000 | (32'(b) << 23);
        d[13:12] = 2'(c);
        eff = (b == 1 && c == 3) ? 2'h1 : 2'(c);
        axi_wr(bic_pkg::ADDR_IMP_CFG, d, 4'h7);
        settle();
        chk(lpf_eff, eff);
        axi_rd(bic_pkg::ADDR_IMP_CFG);
        chk(rd, {d[31:14], eff, d[11:0]});
      end
    end
    // clearing only the rate bit restores the stored 16 Hz code
    axi_wr(bic_pkg::ADDR_IMP_CFG, 32'h00200000, 4'h4);
    settle();
    chk(lpf_eff, 2'h3);
    axi_rd(bic_pkg::ADDR_IMP_CFG);
    chk(rd, 32'h00203000);
    $display("test lowpass done");
    // record disturbance and resynchronize
    chk(disturbed, 1'b1);
    axi_rd(bic_pkg::ADDR_STATUS);
    chk(rd, 32'h1);
    p0 = n_pulse;
    axi_wr(bic_pkg::ADDR_RESYNC, 32'h1, 4'h1);
    settle();
    chk(n_pulse - p0, 32'h1);
    chk(disturbed, 1'b0);
    $display("test resync done");
    // refused accesses leave everything alone
    axi_wr(bic_pkg::ADDR_STATUS, 32'h1, 4'hf);
    chk(resp, 2'h2);
    axi_wr(8'h30, 32'hffffffff, 4'hf);
    chk(resp, 2'h2);
    axi_rd(8'h30);
    chk(resp, 2'h2);
    chk(rd, 32'h0);
    settle();
    chk(disturbed, 1'b0);
    // top byte of the data word is not stored
    axi_wr(bic_pkg::ADDR_IMP_CFG, 32'hff201000, 4'hf);
    axi_rd(bic_pkg::ADDR_IMP_CFG);
    chk(rd, 32'h00201000);
    $display("test refusal done");
    test_done();
  end
endmodule
